/* File: bench/gated_delayed_pulse_counter_modes_test.sv */
// Testbench of the gated delayed pulse counter
`timescale 1ns/10ps
module gated_delayed_pulse_counter_modes_test;
  import gdpc_pkg::*;
  logic clk_sys = 0, rst = 1, arm_cmd = 0, disarm_cmd = 0, gate = 1, run = 0, source;
  gdpc_mode_t mode = 2'h2;
  logic [15:0] load_value = 16'h0003, hold_value = 16'h0002, count;
  logic armed, terminal_count, pulse_out;
  int num_errors = 0, compares = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  gdpc_counter i_dut (.clk_sys(clk_sys), .rst(rst), .mode(mode), .arm_cmd(arm_cmd),
    .disarm_cmd(disarm_cmd), .source(source), .gate(gate), .load_value(load_value),
    .hold_value(hold_value), .count(count), .armed(armed),
    .terminal_count(terminal_count), .pulse_out(pulse_out));
  gdpc_source_model i_src (.clk_sys(clk_sys), .run(run), .source(source));
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic wtc;
    repeat (100) begin
      @(posedge clk_sys);
      #1;
      if (terminal_count === 1'b1) break;
    end
  endtask
  task automatic t_level;
    @(posedge clk_sys) arm_cmd <= 1;
    @(posedge clk_sys) arm_cmd <= 0;
    run <= 1;
    repeat (10) @(posedge clk_sys);
    #1 chk(armed && count === 16'h0003, "level delay not held");
    @(posedge clk_sys) gate <= 0;
    wtc; chk(armed && count === 16'h0002 && pulse_out === 1'b1, "level first tc");
    @(posedge clk_sys) gate <= 1;
    repeat (10) @(posedge clk_sys);
    #1 chk(count === 16'h0002, "level pulse not held");
    @(posedge clk_sys) gate <= 0;
    wtc; chk(!armed && count === 16'h0003 && pulse_out === 1'b0, "level second tc");
    $display("test level done");
  endtask
  task automatic t_edge;
    @(posedge clk_sys) mode <= 2'h1;
    @(posedge clk_sys) gate <= 1;
    @(posedge clk_sys) gate <= 0;
    arm_cmd <= 1;
    @(posedge clk_sys) arm_cmd <= 0;
    repeat (10) @(posedge clk_sys);
    #1 chk(armed && count === 16'h0003, "edge counted untriggered");
    @(posedge clk_sys) gate <= 1;
    @(posedge clk_sys) gate <= 0;
    wtc; chk(armed && count === 16'h0002 && pulse_out === 1'b1, "edge first tc");
    wtc; chk(!armed && count === 16'h0003 && pulse_out === 1'b0, "edge second tc");
    $display("test edge done");
  endtask
  task automatic t_disarm;
    @(posedge clk_sys) mode <= 2'h0;
    @(posedge clk_sys) arm_cmd <= 1;
    @(posedge clk_sys) arm_cmd <= 0;
    #1 chk(armed === 1'b1 && pulse_out === 1'b0, "arm not taken");
    @(posedge clk_sys) disarm_cmd <= 1;
    @(posedge clk_sys) disarm_cmd <= 0;
    #1 chk(armed === 1'b0, "disarm not taken");
    $display("test disarm done");
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      $display("mismatch %0t timeout", $time);
      final_report;
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    t_level;
    t_edge;
    t_disarm;
    final_report;
  end
endmodule

/* File: bench/gdpc_counter_properties.sv */
// Port checker of the gated delayed pulse counter
`timescale 1ns/10ps
module gdpc_counter_checker #(parameter int WIDTH = 16) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire gdpc_pkg::gdpc_mode_t mode,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic gate,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] hold_value,
  input wire logic [WIDTH-1:0] count,
  input wire logic armed,
  input wire logic terminal_count,
  input wire logic pulse_out
);
  import gdpc_pkg::*;
  logic gp;
  logic gr;
  assign gr = (gate ^ mode.gate_active_low) & ~gp;
  always_ff @(posedge clk_sys) gp <= gate ^ mode.gate_active_low;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_tc_from_one: assert property (terminal_count |-> $past(count) == 1)
    else $error("tc not after one");
  a_first_tc_hold: assert property (terminal_count && armed |-> count == $past(hold_value))
    else $error("first tc no hold load");
  a_second_tc_load: assert property (terminal_count && !armed |-> count == $past(load_value))
    else $error("second tc no load");
  a_gate_pause: assert property ($past(armed) && armed && !mode.edge_gated
    && !$past(gate ^ mode.gate_active_low) |-> $stable(count))
    else $error("counted with gate off");
  a_idle_no_tc: assert property (!$past(armed) |-> !terminal_count)
    else $error("tc while disarmed");
  a_arm_start: assert property (arm_cmd && !armed && !disarm_cmd |=> armed && !pulse_out)
    else $error("arm not taken");
  a_edge_wait: assert property ($rose(armed) && mode.edge_gated && !gr ##1 !gr [*3]
    |-> $stable(count))
    else $error("counted before trigger");
  a_pulse_toggle: assert property (terminal_count |-> pulse_out != $past(pulse_out))
    else $error("pulse not toggled");
endmodule
bind gdpc_counter gdpc_counter_checker #(.WIDTH(WIDTH)) i_chk (.clk_sys(clk_sys), .rst(rst),
  .mode(mode), .arm_cmd(arm_cmd), .disarm_cmd(disarm_cmd), .gate(gate),
  .load_value(load_value), .hold_value(hold_value), .count(count), .armed(armed),
  .terminal_count(terminal_count), .pulse_out(pulse_out));

/* File: bench/gdpc_source_model.sv */
// Count source that rises every second cycle while running
`timescale 1ns/10ps
module gdpc_source_model (
  input wire logic clk_sys,
  input wire logic run,
  output logic source
);
  always_ff @(posedge clk_sys) source <= run & ~source;
endmodule

/* File: verilog/gdpc_counter.sv */
// Gated delayed pulse counter, level-gated and edge-triggered one-shot modes
`timescale 1ns/10ps
`include "gdpc_map.svh"
module gdpc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire gdpc_pkg::gdpc_mode_t mode,
  input wire logic arm_cmd,
  input wire logic disarm_cmd,
  input wire logic source,
  input wire logic gate,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] hold_value,
  output logic [WIDTH-1:0] count,
  output logic armed,
  output logic terminal_count,
  output logic pulse_out
);
  import gdpc_pkg::*;

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------
  logic gate_act;
  logic src_rise;
  logic gate_rise;
  assign gate_act = gate ^ mode.gate_active_low;

  gdpc_edge u_src (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(source),
    .rise(src_rise)
  );

  gdpc_edge u_gate (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(gate_act),
    .rise(gate_rise)
  );

  // ---------------------------------------------------------------
  // Count qualification
  // ---------------------------------------------------------------
  gdpc_state_t state;
  gdpc_state_t next_state;
  logic count_en;
  logic at_one;
  logic reach_tc;
  logic in_delay;
  logic [WIDTH-1:0] one;

  assign one = WIDTH'(`GDPC_COUNT_ONE);
  assign at_one = (count == one);
  assign in_delay = (state == GDPC_DELAY);
  assign reach_tc = count_en & at_one;

  always_comb begin
    count_en = 1'b0;
    unique case (state)
      GDPC_IDLE: begin
        count_en = 1'b0;
      end
      GDPC_WAIT: begin
        count_en = 1'b0;
      end
      GDPC_DELAY, GDPC_PULSE: begin
        if (mode.edge_gated) begin
          count_en = src_rise;
        end else begin
          count_en = src_rise & gate_act;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      GDPC_IDLE: begin
        if (arm_cmd) begin
          next_state = mode.edge_gated ? GDPC_WAIT : GDPC_DELAY;
        end
      end
      GDPC_WAIT: begin
        if (gate_rise) begin
          next_state = GDPC_DELAY;
        end
      end
      GDPC_DELAY: begin
        if (reach_tc) begin
          next_state = GDPC_PULSE;
        end
      end
      GDPC_PULSE: begin
        if (reach_tc) begin
          next_state = GDPC_IDLE;
        end
      end
    endcase
    if (disarm_cmd) begin
      next_state = GDPC_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= GDPC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Counter value
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (state == GDPC_IDLE) begin
      if (!arm_cmd) begin
        next_count = load_value;
      end
    end else if (reach_tc) begin
      if (in_delay) begin
        next_count = hold_value;
      end else begin
        next_count = load_value;
      end
    end else if (count_en) begin
      next_count = count - one;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= WIDTH'(`GDPC_COUNT_RESET);
    end else begin
      count <= next_count;
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  logic next_tc;
  logic next_pulse;
  logic next_armed;

  always_comb begin
    next_tc = reach_tc;
    next_pulse = pulse_out;
    if (state == GDPC_IDLE && arm_cmd) begin
      next_pulse = 1'b0;
    end else if (reach_tc) begin
      next_pulse = ~pulse_out;
    end
    next_armed = (next_state != GDPC_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      terminal_count <= 1'b0;
      pulse_out <= 1'b0;
      armed <= 1'b0;
    end else begin
      terminal_count <= next_tc;
      pulse_out <= next_pulse;
      armed <= next_armed;
    end
  end
endmodule

/* File: verilog/gdpc_edge.sv */
// Rising edge detector with registered history
`timescale 1ns/10ps
module gdpc_edge (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  logic last;
  logic next_last;
  always_comb begin
    next_last = level;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last <= level;
    end else begin
      last <= next_last;
    end
  end
  assign rise = level & ~last;
endmodule

/* File: verilog/gdpc_map.svh */
// Constants of the gated delayed pulse counter
// What this block does
// - In level-gated mode only source edges seen while the gate is active are counted.
// - In level-gated mode no source edge is counted unless the counter is armed.
// - In level-gated mode the first terminal count reloads the counter from the hold value.
// - In level-gated mode the second terminal count reloads from the load value and disarms.
// - In level-gated mode an inactive gate stretches both the delay and the pulse phase.
// - Level-gated mode is started by the arm command; the gate only qualifies counting.
// - In edge-triggered mode counting waits for an active gate edge seen while armed.
// - In edge-triggered mode gate edges seen while disarmed are dropped and not remembered.
// - In edge-triggered mode counting starts on the first source edge after the trigger.
// - In edge-triggered mode the phases reload from hold, then from load, as in level mode.
// - In edge-triggered mode the counter disarms itself after the second terminal count.
// - In edge-triggered mode the gate is ignored after the trigger until the second count.
// - Terminal count occurs on the count that follows a counter value of one.
`ifndef GDPC_MAP_SVH
`define GDPC_MAP_SVH
`define GDPC_MODE_LEVEL_BIT 0
`define GDPC_MODE_POL_BIT 1
`define GDPC_MODE_RESET 2'h0
`define GDPC_COUNT_RESET 16'h0000
`define GDPC_COUNT_ONE 16'h0001
`endif

/* File: verilog/gdpc_pkg.sv */
// Types of the gated delayed pulse counter
package gdpc_pkg;
  typedef struct packed {
    logic gate_active_low;
    logic edge_gated;
  } gdpc_mode_t;
  typedef enum logic [1:0] {
    GDPC_IDLE = 2'b00,
    GDPC_WAIT = 2'b01,
    GDPC_DELAY = 2'b10,
    GDPC_PULSE = 2'b11
  } gdpc_state_t;
endpackage
